/* File: pkg/ads_link_if.sv */
`timescale 1ns/1ps
interface ads_link_if;
    // Serial-bus user message
    logic        msg_valid;
    logic [7:0]  msg_addr;
    logic [7:0]  msg_data;
    // A/D words towards the controller
    logic [31:0] ad_data;
    logic        ad_valid;
    logic [7:0]  ad_fifo;
    logic        ad_ready;
    // D/A words from the controller
    logic [31:0] da_data;
    logic        da_valid;
    logic [7:0]  da_fifo;
    logic        da_ready;

    modport dev  (input msg_valid, msg_addr, msg_data, ad_ready, da_data, da_valid, da_fifo,
                  output ad_data, ad_valid, ad_fifo, da_ready);
    modport host (output msg_valid, msg_addr, msg_data, ad_ready, da_data, da_valid, da_fifo,
                  input ad_data, ad_valid, ad_fifo, da_ready);
endinterface

/* File: pkg/ads_pkg.sv */
package ads_pkg;

    // Word and storage shape
    localparam int WORD_W     = 32;
    localparam int FIFO_DEPTH = 511;
    localparam int PTR_W      = 9;
    localparam int SEL_W      = 8;

    // Serial-bus message registers inside the device
    localparam logic [7:0] REG_RD_FIFO = 8'h00;
    localparam logic [7:0] REG_WR_FIFO = 8'h01;
    localparam logic [7:0] REG_ADC_CNT = 8'h02;
    localparam logic [7:0] REG_DAC_CNT = 8'h03;
    localparam int         CNT_BIT     = 0;
    localparam logic [7:0] SEL_RST     = 8'h00;
    localparam logic       CNT_RST     = 1'b0;

    // Packed A/D halfword layout
    localparam int ADC_W    = 12;
    localparam int ADC_OTR  = 12;
    localparam int ADC_THU  = 13;
    localparam int ADC_OVF  = 14;
    localparam int HALF_LSB = 16;

    // Packed D/A sample width
    localparam int DAC_W = 14;

    // Indicator hold time
    localparam int LED_HOLD_MS   = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int LED_HOLD_CYC  = LED_HOLD_MS * 1000000 / CLK_PERIOD_NS;
    localparam int LED_CNT_W     = 24;

    // A/D clock source, fixed per build
    localparam int ADC_CLK_EXT = 0;
    localparam int ADC_CLK_AC  = 1;

    // Controller software registers
    localparam logic [7:0] HR_MSG  = 8'h00;
    localparam logic [7:0] HR_TX   = 8'h04;
    localparam logic [7:0] HR_RX   = 8'h08;
    localparam logic [7:0] HR_STAT = 8'h0C;
    localparam logic [7:0] HR_FIFO = 8'h10;
    localparam int STAT_TX_BUSY  = 0;
    localparam int STAT_RX_VALID = 1;
    localparam int STAT_TAG_LSB  = 8;
    localparam int MSG_ADDR_LSB  = 8;
    localparam int FIFO_WR_LSB   = 8;

    // Which half of a one-channel word is next
    typedef enum logic {ADS_LO, ADS_HI} ads_half_e;

endpackage

/* File: tb/ads_link_properties.sv */
`timescale 1ns/1ps
module ads_link_properties (
    // Clock and reset
    input wire logic        CORE_CLK_I,
    input wire logic        RESETN_I,
    // Link signals
    input wire logic        msg_valid,
    input wire logic [7:0]  msg_addr,
    input wire logic [7:0]  msg_data,
    input wire logic [31:0] ad_data,
    input wire logic        ad_valid,
    input wire logic [7:0]  ad_fifo,
    input wire logic        ad_ready,
    input wire logic [31:0] da_data,
    input wire logic        da_valid,
    input wire logic [7:0]  da_fifo,
    input wire logic        da_ready
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RESETN_I);
    // Offered words that the far end has not yet taken
    sequence ad_stall_s; ad_valid && !ad_ready; endsequence
    sequence da_stall_s; da_valid && !da_ready; endsequence
    ad_hold_a: assert property (ad_stall_s |=> ad_valid && $stable(ad_data))
        else $error("ad word changed while stalled");
    da_hold_a: assert property (da_stall_s |=> da_valid && $stable(da_data) && $stable(da_fifo))
        else $error("da word changed while stalled");
    msg_hold_a: assert property (!msg_valid |-> $stable(msg_addr) && $stable(msg_data))
        else $error("message fields moved without strobe");
    // Tag capture: a lagging copy would mislabel words
    tag_track_a: assert property (msg_valid && msg_addr == ads_pkg::REG_WR_FIFO
                                  |-> ##2 ad_fifo == $past(msg_data, 2))
        else $error("write fifo tag not applied");
    tag_steady_a: assert property (!msg_valid && !$past(msg_valid) |=> $stable(ad_fifo))
        else $error("write fifo tag moved alone");
    zero_bits_a: assert property (ad_valid |-> !ad_data[31] && !ad_data[15])
        else $error("packed zero bit set");
    reset_ready_a: assert property (!$past(RESETN_I) |-> da_ready)
        else $error("da fifo not empty after reset");
    reset_quiet_a: assert property (!$past(RESETN_I) |-> !ad_valid && !msg_valid)
        else $error("link busy after reset");
endmodule

/* File: tb/tb_adc_dac_fifo_streamer.sv */
`timescale 1ns/1ps
module tb_adc_dac_fifo_streamer;
    logic        clk, rst_n, wr, rd, ae, de, ao, at, bo, bt, l_ad, l_da, dwr;
    logic [7:0]  adr;
    logic [31:0] wd, rdat, v;
    logic [11:0] ad, bd;
    logic [13:0] da, db;
    int          bad_count, checks, n_wr;
    ads_link_if link ();
    ads_dev #(.LED_HOLD(20)) i_ads_dev (.CORE_CLK_I(clk), .RESETN_I(rst_n), .LINK(link),
        .ADC_EXT_CLK_I(ae), .ADC_AC_CLK_I(1'b0), .ADC_A_DATA_I(ad), .ADC_A_OTR_I(ao),
        .ADC_A_THU_I(at), .ADC_B_DATA_I(bd), .ADC_B_OTR_I(bo), .ADC_B_THU_I(bt),
        .DAC_EXT_CLK_I(de), .DAC_A_O(da), .DAC_B_O(db), .DAC_WR_O(dwr),
        .ADC_LOSS_LED_O(l_ad), .DAC_UNDERFLOW_LED_O(l_da));
    ads_host i_ads_host (.CORE_CLK_I(clk), .RESETN_I(rst_n), .ADDR_I(adr), .WDATA_I(wd),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .LINK(link));
    ads_link_properties u_prop (.CORE_CLK_I(clk), .RESETN_I(rst_n),
        .msg_valid(link.msg_valid), .msg_addr(link.msg_addr), .msg_data(link.msg_data),
        .ad_data(link.ad_data), .ad_valid(link.ad_valid), .ad_fifo(link.ad_fifo),
        .ad_ready(link.ad_ready), .da_data(link.da_data), .da_valid(link.da_valid),
        .da_fifo(link.da_fifo), .da_ready(link.da_ready));
    ////////////////////////////////////////////////////////////////////////////
    // Core clock, 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Converter strobes; an underflow edge must not add one
    always @(posedge clk) begin
        if (dwr === 1'b1) n_wr <= n_wr + 1;
    end
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk) adr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 d = rdat;
    endtask
    task automatic msg(input logic [7:0] a, input logic [7:0] d);
        wr_reg(ads_pkg::HR_MSG, {16'h0000, a, d});
    endtask
    // Sample clock pulse, about 130 ns per period
    task automatic pulse(input bit dac);
        @(posedge clk) if (dac) de <= 1'b1; else ae <= 1'b1;
        repeat (6) @(posedge clk);
        de <= 1'b0;
        ae <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic results();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog sized well beyond the overflow drain
    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        results();
    end
    // Main sequence
    initial begin
        {wr, rd, ae, de, rst_n} = 5'h00;
        {adr, wd} = 40'h0;
        {ad, bd, ao, at, bo, bt} = {12'h123, 12'hABC, 4'h9};
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ads_pkg::HR_STAT, v); chk(v, 32'h0);
        rd_reg(8'h20, v); chk(v, 32'h0);
        wr_reg(ads_pkg::HR_FIFO, 32'h0305);
        msg(8'h00, 8'h03); msg(8'h01, 8'h05); msg(8'h02, 8'h01);
        // Default single D/A channel; don't-care bits set on purpose
        wr_reg(ads_pkg::HR_TX, 32'hE222C111);
        pulse(1); chk({18'h0, da}, 32'h0111);
        pulse(1); chk({18'h0, da}, 32'h2222);
        msg(8'h03, 8'h01);
        wr_reg(ads_pkg::HR_TX, 32'h15550AAA);
        pulse(1); chk({2'b0, da, 2'b0, db}, 32'h0AAA_1555);
        pulse(1); chk({1'b0, l_da, da, 2'b0, db}, 32'h4AAA_1555);
        chk(n_wr, 32'h3);
        pulse(0);
        rd_reg(ads_pkg::HR_STAT, v); chk(v, 32'h0502);
        rd_reg(ads_pkg::HR_RX, v); chk(v, 32'h2ABC1123);
        // One channel: flood past depth, then drain
        msg(8'h02, 8'h00);
        repeat (1040) pulse(0);
        chk({31'h0, l_ad}, 32'h1);
        rd_reg(ads_pkg::HR_RX, v); chk(v, 32'h11231123);
        pulse(0); pulse(0);
        for (int i = 0; i < 513; i++) begin
            repeat (4) @(posedge clk);
            rd_reg(ads_pkg::HR_RX, v); chk(v, i == 512 ? 32'h11235123 : 32'h11231123);
        end
        repeat (6) @(posedge clk);
        rd_reg(ads_pkg::HR_STAT, v); chk(v, 32'h0500);
        chk({l_ad, l_da}, 2'b00);
        results();
    end
endmodule

/* File: verilog/ads_dev.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser for pins
module ads_sync #(parameter int W = 1) (
    input  wire logic         clk_i,
    input  wire logic         rst_ni,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Flop-based FIFO, registered flags
module ads_fifo (
    input  wire logic        clk_i,
    input  wire logic        rst_ni,
    input  wire logic        push_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        pop_i,
    output logic      [31:0] rdata_o,
    output logic             space_o,
    output logic             avail_o
);
    localparam int D = ads_pkg::FIFO_DEPTH;
    localparam logic [ads_pkg::PTR_W-1:0] LAST = ads_pkg::PTR_W'(D - 1);
    localparam logic [ads_pkg::PTR_W-1:0] FULL = ads_pkg::PTR_W'(D);

    logic [31:0]               mem [D];
    logic [ads_pkg::PTR_W-1:0] wr_ptr_q;
    logic [ads_pkg::PTR_W-1:0] rd_ptr_q;
    logic [ads_pkg::PTR_W-1:0] cnt_q;
    logic [ads_pkg::PTR_W-1:0] cnt_d;
    logic                      do_push;
    logic                      do_pop;

    // Guard against misuse: never write full, never read empty
    assign do_push = push_i && space_o;
    assign do_pop  = pop_i && avail_o;
    assign rdata_o = mem[rd_ptr_q];
    assign cnt_d   = cnt_q + ads_pkg::PTR_W'(do_push) - ads_pkg::PTR_W'(do_pop);

    // Storage has no reset; contents are dead while empty
    always_ff @(posedge clk_i) begin
        if (do_push) begin
            mem[wr_ptr_q] <= wdata_i;
        end
    end

    // Pointers wrap at the odd depth, not a power of two
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            space_o  <= 1'b1;
            avail_o  <= 1'b0;
        end else begin
            if (do_push) begin
                wr_ptr_q <= (wr_ptr_q == LAST) ? '0 : wr_ptr_q + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_q <= (rd_ptr_q == LAST) ? '0 : rd_ptr_q + 1'b1;
            end
            cnt_q   <= cnt_d;
            space_o <= (cnt_d != FULL);
            avail_o <= (cnt_d != '0);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Retriggerable indicator stretcher
module ads_led #(parameter int HOLD = 10) (
    input  wire logic clk_i,
    input  wire logic rst_ni,
    input  wire logic event_i,
    output logic      led_o
);
    logic [ads_pkg::LED_CNT_W-1:0] cnt_q;

    // Each event restarts the full interval
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            cnt_q <= '0;
            led_o <= 1'b0;
        end else if (event_i) begin
            cnt_q <= ads_pkg::LED_CNT_W'(HOLD - 1);
            led_o <= 1'b1;
        end else begin
            cnt_q <= (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;
            led_o <= (cnt_q != '0);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Messages set read and write FIFO numbers
// - Default to one A/D, one D/A channel
// - Register 2 bit 0 picks A/D channels
// - Register 3 bit 0 picks D/A channels
// - Next sample after loss carries overflow flag
// - Loss lights LED, retriggered, tenth second
// - Empty at D/A clock: hold outputs, LED
// - 511-word input FIFO toward link
// - 511-word output FIFO from link
// - One-channel word packs two samples, flags
// - Two-channel word packs A and B
// - Flags copy converter top-half and over-range
// - Write every A/D clock, every second in one-channel mode; drain when possible
// - Fill output FIFO while link has data
// - Each D/A edge with data strobes converters; takes a word every edge, every second in one-channel mode
// - One-channel D/A word: two 14-bit samples
// - Two-channel D/A word: A low, B high
// - A/D clock source per build; D/A separate
// - Link clock within carrier limits
// - General logic on user oscillator clock
// - Controller configures, then streams data
// - Consumer should keep up with sampling
module ads_dev #(
    parameter int ADC_CLK_SEL = ads_pkg::ADC_CLK_EXT,
    parameter int LED_HOLD    = ads_pkg::LED_HOLD_CYC
) (
    // Clock and reset
    input  wire logic         CORE_CLK_I,
    input  wire logic         RESETN_I,
    // Link to controller
    ads_link_if.dev           LINK,
    // A/D converter pins
    input  wire logic         ADC_EXT_CLK_I,
    input  wire logic         ADC_AC_CLK_I,
    input  wire logic [11:0]  ADC_A_DATA_I,
    input  wire logic         ADC_A_OTR_I,
    input  wire logic         ADC_A_THU_I,
    input  wire logic [11:0]  ADC_B_DATA_I,
    input  wire logic         ADC_B_OTR_I,
    input  wire logic         ADC_B_THU_I,
    // D/A converter pins
    input  wire logic         DAC_EXT_CLK_I,
    output logic      [13:0]  DAC_A_O,
    output logic      [13:0]  DAC_B_O,
    output logic              DAC_WR_O,
    // Indicators
    output logic              ADC_LOSS_LED_O,
    output logic              DAC_UNDERFLOW_LED_O
);
    localparam int HL = ads_pkg::HALF_LSB;

    logic [7:0]  rd_sel_q;
    logic [7:0]  wr_sel_q;
    logic        adc_two_q;
    logic        dac_two_q;
    logic [1:0]  clk_s;
    logic        adc_clk_q;
    logic        dac_clk_q;
    logic        adc_edge;
    logic        dac_edge;
    logic [27:0] adc_s;
    logic [15:0] cur_a;
    logic [15:0] cur_b;
    logic [31:0] adc_word;
    logic        adc_push;
    logic        adc_space;
    logic        adc_avail;
    logic [31:0] adc_rdata;
    logic        adc_pop;
    logic        ovf_pend_q;
    logic        adc_loss;
    ads_pkg::ads_half_e adc_half_q;
    logic [15:0] adc_low_q;
    logic        dac_push;
    logic        dac_space;
    logic        dac_avail;
    logic [31:0] dac_rdata;
    logic        dac_pop;
    logic        dac_under;
    ads_pkg::ads_half_e dac_half_q;
    logic [13:0] dac_hold_q;
    logic        cfg_adc;
    logic        cfg_dac;

    ////////////////////////////////////////////////////////////////////////////
    // Message registers; writes take effect at once
    assign cfg_adc = LINK.msg_valid && (LINK.msg_addr == ads_pkg::REG_ADC_CNT);
    assign cfg_dac = LINK.msg_valid && (LINK.msg_addr == ads_pkg::REG_DAC_CNT);

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rd_sel_q  <= ads_pkg::SEL_RST;
            wr_sel_q  <= ads_pkg::SEL_RST;
            adc_two_q <= ads_pkg::CNT_RST;
            dac_two_q <= ads_pkg::CNT_RST;
        end else if (LINK.msg_valid) begin
            if (LINK.msg_addr == ads_pkg::REG_RD_FIFO) begin
                rd_sel_q <= LINK.msg_data;
            end
            if (LINK.msg_addr == ads_pkg::REG_WR_FIFO) begin
                wr_sel_q <= LINK.msg_data;
            end
            if (cfg_adc) begin
                adc_two_q <= LINK.msg_data[ads_pkg::CNT_BIT];
            end
            if (cfg_dac) begin
                dac_two_q <= LINK.msg_data[ads_pkg::CNT_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sample clocks and converter data cross in by two flops each
    ads_sync #(.W(2)) u_clk_sync (
        .clk_i  (CORE_CLK_I),
        .rst_ni (RESETN_I),
        .d_i    ({(ADC_CLK_SEL == ads_pkg::ADC_CLK_AC) ? ADC_AC_CLK_I : ADC_EXT_CLK_I,
                  DAC_EXT_CLK_I}),
        .q_o    (clk_s)
    );
    ads_sync #(.W(28)) u_adc_sync (
        .clk_i  (CORE_CLK_I),
        .rst_ni (RESETN_I),
        .d_i    ({ADC_B_THU_I, ADC_B_OTR_I, ADC_B_DATA_I, ADC_A_THU_I, ADC_A_OTR_I, ADC_A_DATA_I}),
        .q_o    (adc_s)
    );

    // Edge finders on the synchronised sample clocks
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            adc_clk_q <= 1'b0;
            dac_clk_q <= 1'b0;
        end else begin
            adc_clk_q <= clk_s[1];
            dac_clk_q <= clk_s[0];
        end
    end
    assign adc_edge = clk_s[1] && !adc_clk_q;
    assign dac_edge = clk_s[0] && !dac_clk_q;

    ////////////////////////////////////////////////////////////////////////////
    // A/D halfwords: data, over-range, top-half, overflow, zero
    assign cur_a = {1'b0, 1'b0, adc_s[13], adc_s[12], adc_s[11:0]};
    assign cur_b = {1'b0, 1'b0, adc_s[27], adc_s[26], adc_s[25:14]};

    always_comb begin
        adc_word = '0;
        if (adc_two_q) begin
            adc_word = {cur_b, cur_a};
            adc_word[ads_pkg::ADC_OVF]      = ovf_pend_q;
            adc_word[HL + ads_pkg::ADC_OVF] = ovf_pend_q;
        end else begin
            adc_word = {cur_a, adc_low_q};
        end
    end

    // One-channel mode pushes every second sample
    assign adc_push = adc_edge && (adc_two_q || adc_half_q == ads_pkg::ADS_HI);
    assign adc_loss = adc_push && !adc_space;

    // Low half parked; overflow flag rides the first kept sample
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            adc_half_q <= ads_pkg::ADS_LO;
            adc_low_q  <= '0;
            ovf_pend_q <= 1'b0;
        end else begin
            if (adc_edge) begin
                if (!adc_two_q && adc_half_q == ads_pkg::ADS_LO) begin
                    adc_low_q                   <= cur_a;
                    adc_low_q[ads_pkg::ADC_OVF] <= ovf_pend_q;
                    ovf_pend_q                  <= 1'b0;
                    adc_half_q                  <= ads_pkg::ADS_HI;
                end else begin
                    adc_half_q <= ads_pkg::ADS_LO;
                    ovf_pend_q <= adc_loss;
                end
            end
            // Count change restarts pairing; a loss beside it is still flagged
            if (cfg_adc) begin
                adc_half_q <= ads_pkg::ADS_LO;
            end
        end
    end

    ads_fifo u_adc_fifo (
        .clk_i   (CORE_CLK_I),
        .rst_ni  (RESETN_I),
        .push_i  (adc_push),
        .wdata_i (adc_word),
        .pop_i   (adc_pop),
        .rdata_o (adc_rdata),
        .space_o (adc_space),
        .avail_o (adc_avail)
    );

    // Output stage keeps link signals on flops, core clock
    assign adc_pop = adc_avail && (!LINK.ad_valid || LINK.ad_ready);
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            LINK.ad_valid <= 1'b0;
            LINK.ad_data  <= '0;
            LINK.ad_fifo  <= ads_pkg::SEL_RST;
        end else begin
            LINK.ad_fifo <= wr_sel_q;
            if (adc_pop) begin
                LINK.ad_valid <= 1'b1;
                LINK.ad_data  <= adc_rdata;
            end else if (LINK.ad_ready) begin
                LINK.ad_valid <= 1'b0;
            end
        end
    end

    ads_led #(.HOLD(LED_HOLD)) u_adc_led (
        .clk_i   (CORE_CLK_I),
        .rst_ni  (RESETN_I),
        .event_i (adc_loss),
        .led_o   (ADC_LOSS_LED_O)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Words for another FIFO number are taken and dropped
    assign dac_push = LINK.da_valid && LINK.da_ready && (LINK.da_fifo == rd_sel_q);
    assign LINK.da_ready = dac_space;

    ads_fifo u_dac_fifo (
        .clk_i   (CORE_CLK_I),
        .rst_ni  (RESETN_I),
        .push_i  (dac_push),
        .wdata_i (LINK.da_data),
        .pop_i   (dac_pop),
        .rdata_o (dac_rdata),
        .space_o (dac_space),
        .avail_o (dac_avail)
    );

    // High half of a one-channel word needs no fresh pop
    assign dac_pop   = dac_edge && dac_avail && (dac_two_q || dac_half_q == ads_pkg::ADS_LO);
    assign dac_under = dac_edge && !dac_avail && (dac_two_q || dac_half_q == ads_pkg::ADS_LO);

    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            DAC_A_O    <= '0;
            DAC_B_O    <= '0;
            DAC_WR_O   <= 1'b0;
            dac_hold_q <= '0;
            dac_half_q <= ads_pkg::ADS_LO;
        end else begin
            DAC_WR_O <= dac_pop || (dac_edge && !dac_two_q && dac_half_q == ads_pkg::ADS_HI);
            if (dac_pop) begin
                DAC_A_O <= dac_rdata[ads_pkg::DAC_W-1:0];
                if (dac_two_q) begin
                    DAC_B_O <= dac_rdata[HL +: ads_pkg::DAC_W];
                end else begin
                    dac_hold_q <= dac_rdata[HL +: ads_pkg::DAC_W];
                    dac_half_q <= ads_pkg::ADS_HI;
                end
            end else if (dac_edge && !dac_two_q && dac_half_q == ads_pkg::ADS_HI) begin
                DAC_A_O    <= dac_hold_q;
                dac_half_q <= ads_pkg::ADS_LO;
            end
            // Count change restarts pairing; a one-channel word popped beside it loses its high half
            if (cfg_dac) begin
                dac_half_q <= ads_pkg::ADS_LO;
            end
        end
    end

    ads_led #(.HOLD(LED_HOLD)) u_dac_led (
        .clk_i   (CORE_CLK_I),
        .rst_ni  (RESETN_I),
        .event_i (dac_under),
        .led_o   (DAC_UNDERFLOW_LED_O)
    );
endmodule

/* File: verilog/ads_host.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Controller end: software port to serial-bus messages and FIFO words
module ads_host (
    // Clock and reset
    input  wire logic         CORE_CLK_I,
    input  wire logic         RESETN_I,
    // Software register port
    input  wire logic [7:0]   ADDR_I,
    input  wire logic [31:0]  WDATA_I,
    input  wire logic         WR_I,
    input  wire logic         RD_I,
    output logic      [31:0]  RDATA_O,
    // Link to device
    ads_link_if.host          LINK
);
    logic        tx_take;
    logic        rx_take;
    logic        rx_pop;
    logic        rx_full_d;
    logic        rx_full_q;
    logic [7:0]  fifo_rd_q;
    logic [7:0]  fifo_wr_q;
    logic [7:0]  rx_tag_q;
    logic [31:0] rx_data_q;

    assign tx_take   = LINK.da_valid && LINK.da_ready;
    assign rx_take   = LINK.ad_valid && LINK.ad_ready;
    assign rx_pop    = RD_I && (ADDR_I == ads_pkg::HR_RX);
    assign rx_full_d = rx_take || (rx_full_q && !rx_pop);

    ////////////////////////////////////////////////////////////////////////////
    // Software write sends one message pulse; order is software's job
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            LINK.msg_valid <= 1'b0;
            LINK.msg_addr  <= '0;
            LINK.msg_data  <= '0;
        end else begin
            LINK.msg_valid <= WR_I && (ADDR_I == ads_pkg::HR_MSG);
            if (WR_I && ADDR_I == ads_pkg::HR_MSG) begin
                LINK.msg_addr <= WDATA_I[ads_pkg::MSG_ADDR_LSB +: 8];
                LINK.msg_data <= WDATA_I[7:0];
            end
        end
    end

    // Own FIFO numbers; the write number tags outgoing words
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            fifo_rd_q <= ads_pkg::SEL_RST;
            fifo_wr_q <= ads_pkg::SEL_RST;
        end else if (WR_I && ADDR_I == ads_pkg::HR_FIFO) begin
            fifo_rd_q <= WDATA_I[7:0];
            fifo_wr_q <= WDATA_I[ads_pkg::FIFO_WR_LSB +: 8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One-word transmit holding; writes while busy are dropped
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            LINK.da_valid <= 1'b0;
            LINK.da_data  <= '0;
            LINK.da_fifo  <= ads_pkg::SEL_RST;
        end else if (WR_I && ADDR_I == ads_pkg::HR_TX && !LINK.da_valid) begin
            LINK.da_valid <= 1'b1;
            LINK.da_data  <= WDATA_I;
            LINK.da_fifo  <= fifo_wr_q;
        end else if (tx_take) begin
            LINK.da_valid <= 1'b0;
        end
    end

    // One-word receive holding; ready is low while it is full
    // Own full flag, so ready held low in reset is not read as a held word
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            LINK.ad_ready <= 1'b0;
            rx_data_q     <= '0;
            rx_tag_q      <= '0;
            rx_full_q     <= 1'b0;
        end else begin
            rx_full_q     <= rx_full_d;
            LINK.ad_ready <= !rx_full_d;
            if (rx_take) begin
                rx_data_q <= LINK.ad_data;
                rx_tag_q  <= LINK.ad_fifo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data one cycle after the strobe, zero elsewhere
    always_ff @(posedge CORE_CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            RDATA_O <= '0;
        end else begin
            RDATA_O <= '0;
            if (RD_I) begin
                unique case (ADDR_I)
                    ads_pkg::HR_RX:   RDATA_O <= rx_data_q;
                    ads_pkg::HR_FIFO: RDATA_O <= {16'h0000, fifo_wr_q, fifo_rd_q};
                    ads_pkg::HR_STAT: begin
                        RDATA_O[ads_pkg::STAT_TX_BUSY]         <= LINK.da_valid;
                        RDATA_O[ads_pkg::STAT_RX_VALID]        <= !LINK.ad_ready;
                        RDATA_O[ads_pkg::STAT_TAG_LSB +: 8]    <= rx_tag_q;
                    end
                    default:          RDATA_O <= '0;
                endcase
            end
        end
    end
endmodule
